// ===== design/tic_pkg.sv
// shared constants, types and decode helpers for the touch input configuration block
// assumes a single 100 MHz core clock and a register port driven by the serial protocol engine

package tic_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] TIC_ADDR_GEN_CFG = 8'h20;
    localparam logic [7:0] TIC_ADDR_ENABLE = 8'h21;
    localparam logic [7:0] TIC_ADDR_TIMING = 8'h22;
    localparam logic [7:0] TIC_ADDR_HOLD = 8'h23;
    localparam logic [7:0] TIC_ADDR_POLICY = 8'h44;

    localparam logic [7:0] TIC_RST_GEN_CFG = 8'h20;
    localparam logic [7:0] TIC_RST_ENABLE = 8'hff;
    localparam logic [7:0] TIC_RST_TIMING = 8'ha4;
    localparam logic [7:0] TIC_RST_HOLD = 8'h07;
    localparam logic [7:0] TIC_RST_POLICY = 8'h40;

    // writable bits; reserved bits read as zero
    localparam logic [7:0] TIC_MASK_GEN_CFG = 8'hb8;
    localparam logic [7:0] TIC_MASK_ENABLE = 8'hff;
    localparam logic [7:0] TIC_MASK_TIMING = 8'hff;
    localparam logic [7:0] TIC_MASK_HOLD = 8'h0f;
    localparam logic [7:0] TIC_MASK_POLICY = 8'h7f;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int TIC_BIT_TIMEOUT_EN = 3;
    localparam int TIC_BIT_LOWFREQ_DIS = 4;
    localparam int TIC_BIT_BL_IRQ_EN = 4;
    localparam int TIC_BIT_RADIO_ONLY = 3;
    localparam int TIC_BIT_RADIO_DIS = 2;
    localparam int TIC_BIT_CAL_IRQ_EN = 1;
    localparam int TIC_BIT_REL_SUPPRESS = 0;
    localparam int TIC_FLD_MAX_LSB = 4;
    localparam int TIC_FLD_CODE_W = 4;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int TIC_CLK_NS = 10;
    localparam int TIC_TICK_NS = 1000000;
    localparam int TIC_TICK_CYCLES = TIC_TICK_NS / TIC_CLK_NS;
    localparam int TIC_TICK_W = 17;
    localparam int TIC_DUR_W = 14;
    localparam int TIC_RPT_W = 10;
    localparam logic [TIC_RPT_W-1:0] TIC_STEP_MS = 10'h023;
    localparam logic [TIC_DUR_W-1:0] TIC_DUR_SAT = 14'h3fff;

    typedef enum logic [3:0] {
        TIC_IDLE = 4'h1,
        TIC_TOUCH = 4'h2,
        TIC_HELD = 4'h4,
        TIC_WAIT = 4'h8
    } tic_chan_e;

    typedef struct packed {
        tic_chan_e st;
        logic [TIC_DUR_W-1:0] dur_ms;
        logic [TIC_RPT_W-1:0] rpt_ms;
        logic evt;
        logic hold_evt;
        logic recal;
    } tic_chan_s;

    // per-channel timing settings handed down from the register bank
    typedef struct packed {
        logic timeout_en;
        logic rel_suppress;
        logic [TIC_DUR_W-1:0] max_ms;
        logic [TIC_RPT_W-1:0] hold_ms;
        logic [TIC_RPT_W-1:0] rpt_ms;
    } tic_timing_s;

    typedef struct packed {
        logic [7:0] gen_cfg;
        logic [7:0] enable;
        logic [7:0] timing;
        logic [7:0] hold;
        logic [7:0] policy;
        logic [TIC_TICK_W-1:0] tick_cnt;
        logic tick;
        logic bl_prev;
        logic cf_prev;
        logic [7:0] noise_status;
        logic [7:0] touch_ok;
        logic status_evt;
        logic [7:0] rdata;
        logic rvalid;
    } tic_regs_s;

    // steps of 35 ms, code 0 meaning one step
    function automatic logic [TIC_RPT_W-1:0] tic_step_ms(input logic [TIC_FLD_CODE_W-1:0] code);
        tic_step_ms = TIC_RPT_W'(TIC_STEP_MS * ({6'h00, code} + 10'h001));
    endfunction : tic_step_ms

    function automatic logic [TIC_DUR_W-1:0] tic_max_ms(input logic [TIC_FLD_CODE_W-1:0] code);
        case (code)
            4'h0: tic_max_ms = 14'h0230;
            4'h1: tic_max_ms = 14'h0348;
            4'h2: tic_max_ms = 14'h0460;
            4'h3: tic_max_ms = 14'h0578;
            4'h4: tic_max_ms = 14'h0690;
            4'h5: tic_max_ms = 14'h08c0;
            4'h6: tic_max_ms = 14'h0af0;
            4'h7: tic_max_ms = 14'h0d20;
            4'h8: tic_max_ms = 14'h0f50;
            4'h9: tic_max_ms = 14'h1180;
            4'ha: tic_max_ms = 14'h15e0;
            4'hb: tic_max_ms = 14'h1a40;
            4'hc: tic_max_ms = 14'h1ea0;
            4'hd: tic_max_ms = 14'h22ca;
            4'he: tic_max_ms = 14'h2760;
            default: tic_max_ms = 14'h2bc0;
        endcase
    endfunction : tic_max_ms

endpackage : tic_pkg

// ===== design/tic_chan.sv
// one sensor input's press, release, repeat, hold and max-duration timing
// assumes a qualified touch level and a 1 ms tick, both on core_clk

`timescale 1ns/1ns

module tic_chan (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic tick,
    input wire logic touch,
    input wire logic auto_rpt,
    input wire tic_pkg::tic_timing_s cfg,
    output logic evt,
    output logic hold_evt,
    output logic recal
);
    import tic_pkg::*;

    tic_chan_s cur;
    tic_chan_s next_cur;

    // ************************************************************
    // channel state machine
    // ************************************************************
    always_comb begin
        next_cur = cur;
        next_cur.evt = 1'b0;
        next_cur.hold_evt = 1'b0;
        next_cur.recal = 1'b0;
        // counters share the common tick; duration saturates instead of wrapping
        if (tick) begin
            if (cur.dur_ms != TIC_DUR_SAT) begin
                next_cur.dur_ms = cur.dur_ms + 14'h0001;
            end
            next_cur.rpt_ms = cur.rpt_ms + 10'h001;
        end
        case (cur.st)
            TIC_IDLE: begin
                if (touch) begin
                    next_cur.st = TIC_TOUCH;
                    next_cur.dur_ms = '0;
                    next_cur.rpt_ms = '0;
                    next_cur.evt = 1'b1;
                end
            end
            TIC_TOUCH: begin
                if (!touch) begin
                    next_cur.st = TIC_IDLE;
                    next_cur.evt = !cfg.rel_suppress;
                end else if (cfg.timeout_en && cur.dur_ms >= cfg.max_ms) begin
                    next_cur.st = TIC_WAIT;
                    next_cur.recal = 1'b1;
                end else if (auto_rpt && cur.dur_ms > {4'h0, cfg.hold_ms}) begin
                    // equal to the threshold still counts as a plain touch
                    next_cur.st = TIC_HELD;
                    next_cur.hold_evt = 1'b1;
                    next_cur.rpt_ms = '0;
                end
            end
            TIC_HELD: begin
                if (!touch) begin
                    next_cur.st = TIC_IDLE;
                    next_cur.evt = !cfg.rel_suppress;
                end else if (cfg.timeout_en && cur.dur_ms >= cfg.max_ms) begin
                    next_cur.st = TIC_WAIT;
                    next_cur.recal = 1'b1;
                end else if (cur.rpt_ms >= cfg.rpt_ms) begin
                    next_cur.evt = 1'b1;
                    next_cur.rpt_ms = '0;
                end
            end
            TIC_WAIT: begin
                // recalibration absorbs the touch, so its end raises nothing
                if (!touch) begin
                    next_cur.st = TIC_IDLE;
                end
            end
            default: begin
                next_cur.st = TIC_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur <= '{st: TIC_IDLE, default: '0};
        end else begin
            cur <= next_cur;
        end
    end

    assign evt = cur.evt;
    assign hold_evt = cur.hold_evt;
    assign recal = cur.recal;

endmodule : tic_chan

// ===== design/tic_regs.sv
// touch input configuration bank: registers, noise qualification and per-input timing
// assumes a byte register port from the serial protocol engine and sensing logic on core_clk
// the sensing front end hands over levels already on core_clk, so no input is synchronised
// here; a source on another clock must be retimed before it reaches this bank

`timescale 1ns/1ns

module tic_regs #(
    parameter int TICK_CYCLES = tic_pkg::TIC_TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [7:0] touch_raw,
    input wire logic [7:0] radio_noise,
    input wire logic [7:0] lowfreq_noise,
    input wire logic [7:0] auto_repeat_en,
    input wire logic baseline_limit_flag,
    input wire logic calib_fail_flag,
    output logic [7:0] active_input_enable,
    output logic [7:0] touch_qualified,
    output logic [7:0] noise_status,
    output logic [7:0] touch_event,
    output logic [7:0] hold_event,
    output logic [7:0] recal_request,
    output logic status_alert
);
    import tic_pkg::*;

    tic_regs_s cur;
    tic_regs_s next_cur;
    tic_timing_s timing_cfg;
    logic [7:0] blocked;

    // ************************************************************
    // register field views
    // ************************************************************
    logic touch_timeout_enable;
    logic lowfreq_dis;
    logic baseline_limit_irq_en;
    logic report_radio_noise_only;
    logic radio_filter_disable;
    logic calib_fail_irq_en;
    logic release_irq_suppress;
    logic [TIC_FLD_CODE_W-1:0] touch_timeout_code;
    logic [TIC_FLD_CODE_W-1:0] repeat_interval_code;
    logic [TIC_FLD_CODE_W-1:0] hold_threshold_code;

    // single-bit controls, read straight from the stored words
    assign touch_timeout_enable = cur.gen_cfg[TIC_BIT_TIMEOUT_EN];
    assign lowfreq_dis = cur.gen_cfg[TIC_BIT_LOWFREQ_DIS];
    assign baseline_limit_irq_en = cur.policy[TIC_BIT_BL_IRQ_EN];
    assign report_radio_noise_only = cur.policy[TIC_BIT_RADIO_ONLY];
    assign radio_filter_disable = cur.policy[TIC_BIT_RADIO_DIS];
    assign calib_fail_irq_en = cur.policy[TIC_BIT_CAL_IRQ_EN];
    assign release_irq_suppress = cur.policy[TIC_BIT_REL_SUPPRESS];
    // timing codes; the upper nibble of the hold word is reserved and reads zero
    assign touch_timeout_code = cur.timing[TIC_FLD_MAX_LSB +: TIC_FLD_CODE_W];
    assign repeat_interval_code = cur.timing[0 +: TIC_FLD_CODE_W];
    assign hold_threshold_code = cur.hold[0 +: TIC_FLD_CODE_W];

    // decoded timings, shared by all eight inputs; one decoder serves them all
    // because every input runs from the same register fields
    always_comb begin
        timing_cfg.timeout_en = touch_timeout_enable;
        timing_cfg.rel_suppress = release_irq_suppress;
        timing_cfg.max_ms = tic_max_ms(touch_timeout_code);
        timing_cfg.rpt_ms = tic_step_ms(repeat_interval_code);
        timing_cfg.hold_ms = tic_step_ms(hold_threshold_code);
    end

    // ************************************************************
    // noise qualification
    // ************************************************************
    // blocking acts on the delta count whatever the status reporting shows
    assign blocked = (radio_noise & {8{!radio_filter_disable}})
                   | (lowfreq_noise & {8{!lowfreq_dis}});

    // ************************************************************
    // address decode
    // ************************************************************
    // positions in the one-hot register select
    localparam int SEL_GEN_CFG = 0;
    localparam int SEL_ENABLE = 1;
    localparam int SEL_TIMING = 2;
    localparam int SEL_HOLD = 3;
    localparam int SEL_POLICY = 4;
    localparam int SEL_W = 5;

    // one select for the write and the read path, so the two never disagree
    // on which word an address reaches; unmapped addresses select nothing
    function automatic logic [SEL_W-1:0] reg_select(input logic [7:0] addr);
        reg_select = '0;
        reg_select[SEL_GEN_CFG] = (addr == TIC_ADDR_GEN_CFG);
        reg_select[SEL_ENABLE] = (addr == TIC_ADDR_ENABLE);
        reg_select[SEL_TIMING] = (addr == TIC_ADDR_TIMING);
        reg_select[SEL_HOLD] = (addr == TIC_ADDR_HOLD);
        reg_select[SEL_POLICY] = (addr == TIC_ADDR_POLICY);
    endfunction : reg_select

    logic [SEL_W-1:0] sel;
    assign sel = reg_select(reg_addr);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_cur = cur;
        next_cur.rvalid = 1'b0;
        next_cur.status_evt = 1'b0;
        // common 1 ms time base; it runs free, so a press lands anywhere in a tick
        // period and every measured duration carries up to one tick of slack
        next_cur.tick = 1'b0;
        if (cur.tick_cnt == TIC_TICK_W'(TICK_CYCLES - 1)) begin
            next_cur.tick_cnt = '0;
            next_cur.tick = 1'b1;
        end else begin
            next_cur.tick_cnt = cur.tick_cnt + 17'h00001;
        end
        // register writes; reserved bits stay zero, unmapped addresses are ignored
        if (reg_wr && sel[SEL_GEN_CFG]) begin
            next_cur.gen_cfg = reg_wdata & TIC_MASK_GEN_CFG;
        end
        if (reg_wr && sel[SEL_ENABLE]) begin
            next_cur.enable = reg_wdata & TIC_MASK_ENABLE;
        end
        if (reg_wr && sel[SEL_TIMING]) begin
            next_cur.timing = reg_wdata & TIC_MASK_TIMING;
        end
        if (reg_wr && sel[SEL_HOLD]) begin
            next_cur.hold = reg_wdata & TIC_MASK_HOLD;
        end
        if (reg_wr && sel[SEL_POLICY]) begin
            next_cur.policy = reg_wdata & TIC_MASK_POLICY;
        end
        // reads answer one cycle later from the old contents, so a write to the
        // same word in the same cycle shows only at the next read; unmapped read zero
        if (reg_rd) begin
            next_cur.rvalid = 1'b1;
            next_cur.rdata = ({8{sel[SEL_GEN_CFG]}} & cur.gen_cfg)
                           | ({8{sel[SEL_ENABLE]}} & cur.enable)
                           | ({8{sel[SEL_TIMING]}} & cur.timing)
                           | ({8{sel[SEL_HOLD]}} & cur.hold)
                           | ({8{sel[SEL_POLICY]}} & cur.policy);
        end
        // bit n gates sensor input n+1; disabled inputs never touch
        next_cur.touch_ok = touch_raw & cur.enable & ~blocked;
        // noise status reporting
        if (report_radio_noise_only) begin
            next_cur.noise_status = radio_noise;
        end else begin
            next_cur.noise_status = radio_noise | lowfreq_noise;
        end
        // flag edges, so a flag held high alerts only once
        next_cur.bl_prev = baseline_limit_flag;
        next_cur.cf_prev = calib_fail_flag;
        if (baseline_limit_irq_en && baseline_limit_flag && !cur.bl_prev) begin
            next_cur.status_evt = 1'b1;
        end
        if (calib_fail_irq_en && calib_fail_flag && !cur.cf_prev) begin
            next_cur.status_evt = 1'b1;
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur <= '{gen_cfg: TIC_RST_GEN_CFG, enable: TIC_RST_ENABLE, timing: TIC_RST_TIMING,
                     hold: TIC_RST_HOLD, policy: TIC_RST_POLICY, default: '0};
        end else begin
            cur <= next_cur;
        end
    end

    // ************************************************************
    // per-input timing channels
    // ************************************************************
    // eight identical channels on one decoded timing word; only auto repeat is per input
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_chan
            tic_chan u_chan (
                .core_clk(core_clk),
                .rst_b(rst_b),
                .tick(cur.tick),
                .touch(cur.touch_ok[gi]),
                .auto_rpt(auto_repeat_en[gi]),
                .cfg(timing_cfg),
                .evt(touch_event[gi]),
                .hold_evt(hold_event[gi]),
                .recal(recal_request[gi])
            );
        end
    endgenerate

    // outputs straight from registers
    assign reg_rdata = cur.rdata;
    assign reg_rvalid = cur.rvalid;
    assign active_input_enable = cur.enable;
    assign touch_qualified = cur.touch_ok;
    assign noise_status = cur.noise_status;
    assign status_alert = cur.status_evt;

endmodule : tic_regs

// ===== tb/tic_regs_properties.sv
// port checker for the touch configuration bank
// assumes binding into tic_regs, with policy changed only by port writes
`timescale 1ns/1ns
module tic_regs_properties (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic reg_rvalid,
    input wire logic [7:0] touch_raw,
    input wire logic [7:0] radio_noise,
    input wire logic [7:0] lowfreq_noise,
    input wire logic baseline_limit_flag,
    input wire logic calib_fail_flag,
    input wire logic [7:0] active_input_enable,
    input wire logic [7:0] touch_qualified,
    input wire logic [7:0] noise_status,
    input wire logic [7:0] touch_event,
    input wire logic status_alert
);
    import tic_pkg::*;
    logic [7:0] pol;
    logic ten;
    logic bl_q;
    logic cf_q;
    logic cause;
    // ************************************************************
    // shadow state
    // ************************************************************
    // policy mirrored from writes so checks follow the live setting
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pol <= TIC_RST_POLICY;
            ten <= 1'b0;
            bl_q <= 1'b0;
            cf_q <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == TIC_ADDR_POLICY) begin
                pol <= reg_wdata & TIC_MASK_POLICY;
            end
            if (reg_wr && reg_addr == TIC_ADDR_GEN_CFG) begin
                ten <= reg_wdata[TIC_BIT_TIMEOUT_EN];
            end
            bl_q <= baseline_limit_flag;
            cf_q <= calib_fail_flag;
        end
    end
    // only an enabled rising flag may alert
    assign cause = (baseline_limit_flag & ~bl_q & pol[TIC_BIT_BL_IRQ_EN])
        | (calib_fail_flag & ~cf_q & pol[TIC_BIT_CAL_IRQ_EN]);
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence s_press;
        $rose(touch_qualified[0]);
    endsequence
    sequence s_release;
        $fell(touch_qualified[0]);
    endsequence
    a_read_answered: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
    a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray read answer");
    a_enable_write: assert property (reg_wr && reg_addr == TIC_ADDR_ENABLE |=>
        active_input_enable == $past(reg_wdata)) else $error("enable write lost");
    a_touch_gated: assert property ((touch_qualified & ~$past(touch_raw & active_input_enable)) == 8'h00)
        else $error("touch on disabled input");
    a_radio_block: assert property ((touch_qualified
        & $past(radio_noise & ~{8{pol[TIC_BIT_RADIO_DIS]}})) == 8'h00) else $error("radio noise not blocked");
    a_noise_source: assert property ((noise_status & ~$past(radio_noise
        | (lowfreq_noise & ~{8{pol[TIC_BIT_RADIO_ONLY]}}))) == 8'h00) else $error("noise status wrong");
    a_alert_cause: assert property (status_alert == $past(cause)) else $error("alert wrong");
    a_press_event: assert property (s_press |=> touch_event[0]) else $error("no press event");
    a_release_event: assert property (s_release ##0 !pol[0] && !ten |=> touch_event[0])
        else $error("no release event");
    a_release_quiet: assert property (s_release ##0 pol[0] |=> !touch_event[0])
        else $error("release event not suppressed");
endmodule : tic_regs_properties

// ===== tb/tic_host_model.sv
// host register master for the touch configuration bank
// assumes strobes sampled on the rising core_clk edge, one byte each
`timescale 1ns/1ns
module tic_host_model (
    input wire logic core_clk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    // idle bus at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // one write strobe; data inverted afterwards so nothing stale looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~v;
    endtask : wr
    // read strobe, data taken at the edge where the answer is valid
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        v = reg_rvalid ? reg_rdata : 8'hxx;
    endtask : rd
endmodule : tic_host_model

// ===== tb/tic_regs_test.sv
// self-checking bench for the touch configuration bank
// assumes a 100 MHz clock and a 10-cycle tick standing in for 1 ms
`timescale 1ns/1ns
module tic_regs_test;
    import tic_pkg::*;
    localparam int TK = 10;
    logic core_clk, rst_b, reg_wr, reg_rd, reg_rvalid, status_alert;
    logic baseline_limit_flag, calib_fail_flag;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, touch_raw, radio_noise, lowfreq_noise;
    logic [7:0] auto_repeat_en, active_input_enable, touch_qualified, noise_status;
    logic [7:0] touch_event, hold_event, recal_request, d, e, p, g;
    logic [31:0] lfsr = 32'h000126a8;
    logic [7:0] adr [5] = '{TIC_ADDR_GEN_CFG, TIC_ADDR_ENABLE, TIC_ADDR_TIMING, TIC_ADDR_HOLD, TIC_ADDR_POLICY};
    logic [7:0] rsv [5] = '{TIC_RST_GEN_CFG, TIC_RST_ENABLE, TIC_RST_TIMING, TIC_RST_HOLD, TIC_RST_POLICY};
    logic [7:0] msk [5] = '{TIC_MASK_GEN_CFG, TIC_MASK_ENABLE, TIC_MASK_TIMING, TIC_MASK_HOLD, TIC_MASK_POLICY};
    int n_fail = 0, tests_run = 0, n_ev = 0, n_hold = 0, n_recal = 0, n_alert = 0, cycles = 0;
    tic_regs #(.TICK_CYCLES(TK)) dut_u (.*);
    tic_host_model host_u (.*);
    // ************************************************************
    // helpers
    // ************************************************************
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // tallies taken mid-cycle where outputs are settled; the ceiling cuts a hang
    always @(negedge core_clk) begin
        n_ev += int'(touch_event[0]);
        n_hold += int'(hold_event[0]);
        n_recal += int'(recal_request[0]);
        n_alert += int'(status_alert);
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            summarize();
        end
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    // a touch survives when enabled and no unfiltered noise sits on it
    function automatic logic [7:0] qual_exp(input logic [7:0] raw, en, rn, lf, pl, gc);
        qual_exp = raw & en & ~(rn & ~{8{pl[TIC_BIT_RADIO_DIS]}}) & ~(lf & ~{8{gc[TIC_BIT_LOWFREQ_DIS]}});
    endfunction : qual_exp
    function automatic logic [7:0] noise_exp(input logic [7:0] rn, lf, pl);
        noise_exp = rn | (lf & ~{8{pl[TIC_BIT_RADIO_ONLY]}});
    endfunction : noise_exp
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc
    task automatic do_reset;
        rst_b <= 1'b0;
        cyc(20);
        rst_b <= 1'b1;
    endtask : do_reset
    // input one held for ms ticks then released, tallies cleared first
    task automatic press(input int ms);
        n_ev = 0;
        n_hold = 0;
        n_recal = 0;
        touch_raw <= 8'h01;
        cyc(ms * TK);
        touch_raw <= 8'h00;
        cyc(5);
    endtask : press
    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        rst_b = 1'b0;
        touch_raw = 8'h00;
        radio_noise = 8'h00;
        lowfreq_noise = 8'h00;
        auto_repeat_en = 8'h00;
        baseline_limit_flag = 1'b0;
        calib_fail_flag = 1'b0;
        do_reset();
        // reset values, random write-back through the masks, unmapped place
        for (int i = 0; i < 5; i++) begin
            host_u.rd(adr[i], d);
            check(d, rsv[i]);
            lfsr = lfsr_next(lfsr);
            host_u.wr(adr[i], lfsr[7:0]);
            host_u.rd(adr[i], d);
            check(d, lfsr[7:0] & msk[i]);
        end
        host_u.rd(8'h30, d);
        check(d, 8'h00);
        // random enables, noise filters and touches
        for (int i = 0; i < 16; i++) begin
            lfsr = lfsr_next(lfsr);
            e = lfsr[7:0];
            p = lfsr[15:8] & 8'h0c;
            g = lfsr[23:16] & 8'h10;
            host_u.wr(TIC_ADDR_ENABLE, e);
            host_u.wr(TIC_ADDR_POLICY, p);
            host_u.wr(TIC_ADDR_GEN_CFG, g);
            lfsr = lfsr_next(lfsr);
            touch_raw <= lfsr[7:0];
            radio_noise <= lfsr[15:8];
            lowfreq_noise <= lfsr[23:16] ^ lfsr[31:24];
            cyc(2);
            check(touch_qualified, qual_exp(lfsr[7:0], e, lfsr[15:8], lfsr[23:16] ^ lfsr[31:24], p, g));
            check(noise_status, noise_exp(lfsr[15:8], lfsr[23:16] ^ lfsr[31:24], p));
        end
        touch_raw <= 8'h00;
        radio_noise <= 8'h00;
        lowfreq_noise <= 8'h00;
        do_reset();
        // each flag raised with its enable on and off
        for (int k = 0; k < 4; k++) begin
            host_u.wr(TIC_ADDR_POLICY, {3'h0, k[1], 2'h0, k[0], 1'h0});
            n_alert = 0;
            baseline_limit_flag <= 1'b1;
            cyc(4);
            calib_fail_flag <= 1'b1;
            cyc(4);
            baseline_limit_flag <= 1'b0;
            calib_fail_flag <= 1'b0;
            cyc(2);
            check(8'(n_alert), 8'(k[1]) + 8'(k[0]));
        end
        // release event with and without suppression
        for (int k = 0; k < 2; k++) begin
            host_u.wr(TIC_ADDR_POLICY, 8'(k));
            press(3);
            check(8'(n_ev), 8'(2 - k));
        end
        // shortest hold threshold and repeat interval, release suppressed
        host_u.wr(TIC_ADDR_TIMING, 8'h00);
        host_u.wr(TIC_ADDR_HOLD, 8'h00);
        auto_repeat_en <= 8'h01;
        press(30);
        check(8'(n_hold), 8'h00);
        check(8'(n_ev), 8'h01);
        press(150);
        check(8'(n_hold), 8'h01);
        check(8'(n_ev), 8'h04);
        // long touch without and with the timeout enable
        auto_repeat_en <= 8'h00;
        host_u.wr(TIC_ADDR_POLICY, 8'h00);
        press(600);
        check(8'(n_recal), 8'h00);
        host_u.wr(TIC_ADDR_GEN_CFG, 8'h28);
        press(600);
        check(8'(n_recal), 8'h01);
        check(8'(n_ev), 8'h01);
        summarize();
    end
endmodule : tic_regs_test
bind tic_regs tic_regs_properties prop_u (.*);
